// file: bench/sadc_analog_model.sv
// Behavioural analog front end and clock-module reference for the SAR sequencer.
// Assumes one hclk domain; each channel carries a fixed level built from its number.
module sadc_analog_model (
  // Clock
  input  wire logic       hclk,
  // From converter
  input  wire logic [9:0] dac_code,
  input  wire logic [4:0] sel_channel,
  input  wire logic       sar_power_on,
  // To converter
  output logic            comp_hi,
  output logic            clock_module_ext_ref_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] level;
  logic       junk_ff;
  // Level differs per channel so a wrong input mux shows in the result
  assign level = {sel_channel, 5'h15};
  // A powered-down comparator says nothing useful; let it wander
  initial junk_ff = 1'b0;
  always @(posedge hclk) junk_ff <= ~junk_ff;
  assign comp_hi = sar_power_on ? (level >= dac_code) : junk_ff;
  // Clock-module reference runs free and is unrelated to hclk
  initial clock_module_ext_ref_out = 1'b0;
  always #37 clock_module_ext_ref_out = ~clock_module_ext_ref_out;
endmodule

// file: bench/tb.sv
// Self-checking bench for the SAR sequencer through its AHB-Lite registers.
// Assumes a zero-wait-state slave and the analog model in sadc_analog_model.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, comp_hi, ext_ref, hreadyout, hresp, irq;
  logic        sar_power_on, sample_en, got;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [9:0]  dac_code;
  logic [4:0]  sel_channel;
  logic [3:0]  analog_pin_enable;
  int          failures, num_checks, samp_cnt, dv;
  logic [4:0]  chs [5] = '{5'h1B, 5'h1A, 5'h00, 5'h03, 5'h1E};
  logic [1:0]  cks [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  logic [7:0]  cmp_sc2 [4] = '{8'h30, 8'h30, 8'h20, 8'h20};
  logic [9:0]  cmp_val [4] = '{10'h080, 10'h075, 10'h075, 10'h076};
  logic        cmp_hit [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

  always #2.5 hclk = ~hclk;
  always @(posedge hclk) if (sample_en === 1'b1) samp_cnt++;

  sadc_core sadc_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .comp_hi(comp_hi),
    .clock_module_ext_ref_out(ext_ref), .dac_code(dac_code), .sel_channel(sel_channel),
    .sar_power_on(sar_power_on), .sample_en(sample_en),
    .analog_pin_enable(analog_pin_enable), .irq(irq));
  sadc_analog_model sadc_analog_model_i (.hclk(hclk), .dac_code(dac_code),
    .sel_channel(sel_channel), .sar_power_on(sar_power_on), .comp_hi(comp_hi),
    .clock_module_ext_ref_out(ext_ref));

  task automatic summarize();
    if (failures == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for hready at a rising edge
  task automatic edge_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      failures++;
      summarize();
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rv);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    edge_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    edge_ready();
    rv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] junk;
    xfer(1'b1, a, wd, junk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    xfer(1'b0, a, 32'h0, v);
  endtask

  task automatic poll_done(input int bound, output logic g);
    logic [31:0] v;
    g = 1'b0;
    for (int i = 0; i < bound && !g; i++) begin
      rd(sadc_pkg::OFS_SC1, v);
      g = (v[7] === 1'b1);
    end
  endtask

  function automatic logic [31:0] level(input logic [4:0] ch, input logic m10);
    return m10 ? {22'h0, ch, 5'h15} : {24'h0, ch, 3'h5};
  endfunction

  // Software start, bounded wait for done, result compare
  task automatic conv(input logic [31:0] sc1, input logic m10);
    wr(sadc_pkg::OFS_SC1, sc1);
    poll_done(100, got);
    check({31'h0, got}, 32'h1);
    rd(sadc_pkg::OFS_RES, d);
    check(d, level(sc1[4:0], m10));
  endtask

  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    failures = 0; num_checks = 0; samp_cnt = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check({27'h0, sel_channel}, 32'h1F);
    check({31'h0, sar_power_on}, 32'h0);
    rd(sadc_pkg::OFS_SC1, d);
    check(d, 32'h1F);
    rd(8'h40, d);
    check(d, 32'h0);
    check({31'h0, hresp}, 32'h0);
    wr(sadc_pkg::OFS_PIN, 32'hA);
    rd(sadc_pkg::OFS_PIN, d);
    check(d, 32'hA);
    check({28'h0, analog_pin_enable}, 32'hA);
    wr(sadc_pkg::OFS_CFG, 32'h7);
    // Bandgap, then temperature, then ordinary inputs, on the slowest clock
    for (int i = 0; i < 5; i++) begin
      conv({27'h0, chs[i]}, 1'b1);
      check({27'h0, sel_channel}, {27'h0, chs[i]});
    end
    rd(sadc_pkg::OFS_SC2, d);
    check({31'h0, d[7]}, 32'h0);
    check({31'h0, sample_en}, 32'h0);
    wr(sadc_pkg::OFS_CFG, 32'h0);
    conv(32'h3, 1'b0);
    // Sample phase length reveals the tick rate of each clock choice
    for (int i = 0; i < 4; i++) begin
      dv = (cks[i] == 2'h1) ? 2 : (cks[i] == 2'h3) ? sadc_pkg::ASYNC_DIV : 1;
      wr(sadc_pkg::OFS_CFG, 32'h4 | {30'h0, cks[i]});
      rd(sadc_pkg::OFS_CFG, d);
      check({30'h0, d[1:0]}, {30'h0, (cks[i] == 2'h2) ? 2'h0 : cks[i]});
      samp_cnt = 0;
      conv(32'h3, 1'b1);
      check({31'h0, (samp_cnt >= ((dv == 1) ? 2 : dv + 1) && samp_cnt <= 2 * dv)},
            32'h1);
    end
    wr(sadc_pkg::OFS_SC1, 32'h1);
    repeat (4) @(posedge hclk);
    wr(sadc_pkg::OFS_SC1, 32'h2);
    rd(sadc_pkg::OFS_SC1, d);
    check(d, 32'h2);
    poll_done(100, got);
    rd(sadc_pkg::OFS_RES, d);
    check(d, level(5'h2, 1'b1));
    rd(sadc_pkg::OFS_SC1, d);
    check(d, 32'h2);
    wr(sadc_pkg::OFS_SC1, 32'h5);
    poll_done(100, got);
    wr(sadc_pkg::OFS_SC1, 32'h1F);
    rd(sadc_pkg::OFS_SC1, d);
    check(d, 32'h1F);
    wr(sadc_pkg::OFS_SC1, 32'h22);
    poll_done(100, got);
    rd(sadc_pkg::OFS_RES, d);
    check(d, level(5'h2, 1'b1));
    poll_done(100, got);
    check({31'h0, got}, 32'h1);
    wr(sadc_pkg::OFS_SC1, 32'h1F);
    repeat (3) @(posedge hclk);
    check({31'h0, sar_power_on}, 32'h0);
    rd(sadc_pkg::OFS_SC2, d);
    check({31'h0, d[7]}, 32'h0);
    poll_done(30, got);
    check({31'h0, got}, 32'h0);
    // Level of channel 3 is 0x075: hit and miss for both compare senses
    for (int i = 0; i < 4; i++) begin
      wr(sadc_pkg::OFS_CMP, {22'h0, cmp_val[i]});
      wr(sadc_pkg::OFS_SC2, {24'h0, cmp_sc2[i]});
      wr(sadc_pkg::OFS_SC1, 32'h3);
      poll_done(40, got);
      check({31'h0, got}, {31'h0, cmp_hit[i]});
    end
    wr(sadc_pkg::OFS_SC2, 32'h0);
    wr(sadc_pkg::OFS_IEN, 32'h0);
    wr(sadc_pkg::OFS_ICLR, 32'h3);
    conv(32'h3, 1'b1);
    check({31'h0, irq}, 32'h0);
    rd(sadc_pkg::OFS_IST, d);
    check({31'h0, d[0]}, 32'h1);
    wr(sadc_pkg::OFS_IEN, 32'h1);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h1);
    wr(sadc_pkg::OFS_ICLR, 32'h1);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    wr(sadc_pkg::OFS_IEN, 32'h0);
    wr(sadc_pkg::OFS_SC1, 32'h43);
    poll_done(100, got);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h1);
    rd(sadc_pkg::OFS_RES, d);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    // Hardware trigger from the wake-up counter at its shortest period
    wr(sadc_pkg::OFS_ICLR, 32'h3);
    wr(sadc_pkg::OFS_WKP, 32'h0);
    wr(sadc_pkg::OFS_SC2, 32'h40);
    wr(sadc_pkg::OFS_SC1, 32'h4);
    poll_done(7000, got);
    check({31'h0, got}, 32'h1);
    rd(sadc_pkg::OFS_IST, d);
    check({31'h0, d[1]}, 32'h1);
    rd(sadc_pkg::OFS_RES, d);
    check(d, level(5'h4, 1'b1));
    // Same trigger counted from the clock-module reference edges
    wr(sadc_pkg::OFS_WKP, 32'h10);
    wr(sadc_pkg::OFS_ICLR, 32'h2);
    repeat (60) @(posedge hclk);
    rd(sadc_pkg::OFS_IST, d);
    check({31'h0, d[1]}, 32'h1);
    summarize();
  end
endmodule

// file: logic/sadc_core.sv
// SAR converter sequencer: AHB-Lite registers, clock select, triggering, SAR, compare, irq.
// Assumes the analog comparator answers comp_hi within one conversion clock of each trial.
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
module sadc_core (
  // AHB-Lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Analog front end
  input  wire logic        comp_hi,
  input  wire logic        clock_module_ext_ref_out,
  output logic [9:0]       dac_code,
  output logic [4:0]       sel_channel,
  output logic             sar_power_on,
  output logic             sample_en,
  output logic [3:0]       analog_pin_enable,
  // Interrupt
  output logic             irq
);
  logic [31:0]               addr_ff;
  logic                      wr_ff;
  sadc_pkg::sadc_cfg_t       cfg_ff;
  logic                      aien_ff;
  logic [9:0]                cmp_val_ff;
  logic [3:0]                analog_pin_enable_reg_ff;
  logic                      ext_ref_ff;
  logic [3:0]                period_ff;
  logic [sadc_pkg::IRQ_BITS-1:0] ist_ff;
  logic [sadc_pkg::IRQ_BITS-1:0] ien_ff;
  logic                      done_ff;
  logic [9:0]                res_ff;
  logic [9:0]                sar_ff;
  logic [9:0]                bit_ff;
  sadc_pkg::sadc_state_t     state_ff;
  logic [2:0]                div_ff;
  logic [2:0]                smp_ff;
  logic                      hw_conversion_trigger;
  logic                      conv_tick;
  logic                      sc1_wr;
  logic                      low_rd;
  logic                      setup;
  logic                      start;
  logic                      finish;
  logic                      cmp_true;
  logic [9:0]                final_code;
  logic [31:0]               rdata;

  function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
    hit = (a[7:0] == ofs);
  endfunction

  // Address phase capture; the slave never waits
  assign setup = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_ff <= 32'h0000_0000;
      wr_ff   <= 1'b0;
    end else begin
      if (hready) begin
        addr_ff <= haddr;
        wr_ff   <= setup & hwrite;
      end
    end
  end

  assign sc1_wr = wr_ff & hit(addr_ff, sadc_pkg::OFS_SC1);
  assign low_rd = setup & ~hwrite & hit(haddr, sadc_pkg::OFS_RES);

  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff                   <= '{clk_sel: sadc_pkg::CLK_BUS, channel: sadc_pkg::CH_OFF,
                                    default: 1'b0};
      aien_ff                  <= 1'b0;
      cmp_val_ff               <= 10'h000;
      analog_pin_enable_reg_ff <= 4'h0;
      ext_ref_ff               <= 1'b0;
      period_ff                <= sadc_pkg::WKP_RST;
      ien_ff                   <= '0;
    end else if (wr_ff) begin
      if (sc1_wr) begin
        aien_ff        <= hwdata[sadc_pkg::SC1_AIEN];
        cfg_ff.cont    <= hwdata[sadc_pkg::SC1_CONT];
        cfg_ff.channel <= hwdata[4:0];
      end
      if (hit(addr_ff, sadc_pkg::OFS_SC2)) begin
        cfg_ff.hw_trig <= hwdata[sadc_pkg::SC2_HWTRG];
        cfg_ff.cmp_en  <= hwdata[sadc_pkg::SC2_CMPEN];
        cfg_ff.cmp_gt  <= hwdata[sadc_pkg::SC2_CMPGT];
      end
      if (hit(addr_ff, sadc_pkg::OFS_CMP)) cmp_val_ff <= hwdata[9:0];
      if (hit(addr_ff, sadc_pkg::OFS_CFG)) begin
        // The alternate input is absent: that code falls back to the bus clock
        cfg_ff.clk_sel <= (hwdata[1:0] == sadc_pkg::CLK_ALT) ? sadc_pkg::CLK_BUS
                                                             : hwdata[1:0];
        cfg_ff.mode10  <= hwdata[sadc_pkg::CFG_MODE10];
      end
      if (hit(addr_ff, sadc_pkg::OFS_PIN)) analog_pin_enable_reg_ff <= hwdata[3:0];
      if (hit(addr_ff, sadc_pkg::OFS_WKP)) begin
        period_ff  <= hwdata[3:0];
        ext_ref_ff <= hwdata[4];
      end
      if (hit(addr_ff, sadc_pkg::OFS_IEN)) ien_ff <= hwdata[sadc_pkg::IRQ_BITS-1:0];
    end
  end

  sadc_wakeup_ctr u_wakeup (
    .hclk                     (hclk),
    .hresetn                  (hresetn),
    .use_ext_ref              (ext_ref_ff),
    .period_sel               (period_ff),
    .clock_module_ext_ref_out (clock_module_ext_ref_out),
    .overflow                 (hw_conversion_trigger)
  );

  // Conversion clock enable: bus, bus/2, or local divided clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) div_ff <= 3'h0;
    else if (div_ff == 3'(sadc_pkg::ASYNC_DIV - 1)) div_ff <= 3'h0;
    else div_ff <= div_ff + 3'h1;
  end
  always_comb begin
    case (cfg_ff.clk_sel)
      sadc_pkg::CLK_BUS2:  conv_tick = div_ff[0];
      sadc_pkg::CLK_ASYNC: conv_tick = (div_ff == 3'h0);
      default:             conv_tick = 1'b1;
    endcase
  end

  // Start sources
  assign start = (cfg_ff.channel != sadc_pkg::CH_OFF) &&
                 (cfg_ff.hw_trig ? hw_conversion_trigger : 1'b0);

  assign final_code = comp_hi ? sar_ff : (sar_ff & ~bit_ff);
  assign cmp_true   = cfg_ff.cmp_gt ? (final_code >= cmp_val_ff)
                                    : (final_code <  cmp_val_ff);
  assign finish     = (state_ff == sadc_pkg::ST_SAR) && conv_tick && bit_ff[0];

  // SAR sequencer; dac_code moves with sar_ff so the comparator judges the live trial
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= sadc_pkg::ST_IDLE;
      sar_ff   <= 10'h000;
      dac_code <= 10'h000;
      bit_ff   <= 10'h000;
      smp_ff   <= 3'h0;
    end else if (sc1_wr) begin
      // Abort whatever runs; restart only on software trigger and a live channel
      if (hwdata[4:0] != sadc_pkg::CH_OFF && !cfg_ff.hw_trig) begin
        state_ff <= sadc_pkg::ST_SAMPLE;
        smp_ff   <= 3'h0;
      end else state_ff <= sadc_pkg::ST_IDLE;
    end else if (cfg_ff.channel == sadc_pkg::CH_OFF) begin
      state_ff <= sadc_pkg::ST_IDLE;
    end else begin
      case (state_ff)
        sadc_pkg::ST_IDLE: begin
          if (start) begin
            state_ff <= sadc_pkg::ST_SAMPLE;
            smp_ff   <= 3'h0;
          end
        end
        sadc_pkg::ST_SAMPLE: begin
          if (conv_tick) begin
            if (smp_ff == 3'(sadc_pkg::SAMPLE_CYC - 1)) begin
              state_ff <= sadc_pkg::ST_SAR;
              sar_ff   <= 10'h200;
              dac_code <= 10'h200;
              bit_ff   <= 10'h200;
            end else smp_ff <= smp_ff + 3'h1;
          end
        end
        sadc_pkg::ST_SAR: begin
          if (conv_tick) begin
            if (bit_ff[0]) state_ff <= sadc_pkg::ST_DONE;
            else begin
              sar_ff <= final_code | (bit_ff >> 1);
              dac_code <= final_code | (bit_ff >> 1);
              bit_ff <= bit_ff >> 1;
            end
          end
        end
        sadc_pkg::ST_DONE: begin
          // Continuous restarts itself; single goes back to idle
          state_ff <= cfg_ff.cont ? sadc_pkg::ST_SAMPLE : sadc_pkg::ST_IDLE;
          smp_ff   <= 3'h0;
        end
        default: state_ff <= sadc_pkg::ST_IDLE;
      endcase
    end
  end

  // Result register and done flag; a completion beats a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_ff  <= 10'h000;
      done_ff <= 1'b0;
    end else begin
      if (finish && (!cfg_ff.cmp_en || cmp_true)) begin
        res_ff  <= cfg_ff.mode10 ? final_code : {2'b00, final_code[9:2]};
        done_ff <= 1'b1;
      end else if (sc1_wr || low_rd) done_ff <= 1'b0;
    end
  end

  // Sticky interrupt status: done and trigger events
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ist_ff <= '0;
    else begin
      for (int i = 0; i < sadc_pkg::IRQ_BITS; i++) begin
        if (wr_ff && hit(addr_ff, sadc_pkg::OFS_ICLR) && hwdata[i]) ist_ff[i] <= 1'b0;
        if (i == sadc_pkg::IRQ_DONE && finish && (!cfg_ff.cmp_en || cmp_true))
          ist_ff[i] <= 1'b1;
        if (i == sadc_pkg::IRQ_TRIG && hw_conversion_trigger) ist_ff[i] <= 1'b1;
      end
    end
  end

  // Read mux decodes the address phase so hrdata stands for the whole data phase
  // A read right behind a write sees the register as it was before that write
  always_comb begin
    rdata = 32'h0000_0000;
    case (haddr[7:0])
      sadc_pkg::OFS_SC1: rdata = {24'h0, done_ff, aien_ff, cfg_ff.cont, cfg_ff.channel};
      sadc_pkg::OFS_SC2: rdata = {24'h0, state_ff != sadc_pkg::ST_IDLE, cfg_ff.hw_trig,
                                  cfg_ff.cmp_en, cfg_ff.cmp_gt, 4'h0};
      sadc_pkg::OFS_RES: rdata = {22'h0, res_ff};
      sadc_pkg::OFS_CMP: rdata = {22'h0, cmp_val_ff};
      sadc_pkg::OFS_CFG: rdata = {29'h0, cfg_ff.mode10, cfg_ff.clk_sel};
      sadc_pkg::OFS_PIN: rdata = {28'h0, analog_pin_enable_reg_ff};
      sadc_pkg::OFS_WKP: rdata = {27'h0, ext_ref_ff, period_ff};
      sadc_pkg::OFS_IST: rdata = {30'h0, ist_ff};
      sadc_pkg::OFS_IEN: rdata = {30'h0, ien_ff};
      default:           rdata = 32'h0000_0000;
    endcase
  end

  // Registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata            <= 32'h0000_0000;
      hreadyout         <= 1'b1;
      hresp             <= 1'b0;
      sel_channel       <= sadc_pkg::CH_OFF;
      sar_power_on      <= 1'b0;
      sample_en         <= 1'b0;
      analog_pin_enable <= 4'h0;
      irq               <= 1'b0;
    end else begin
      hreadyout         <= 1'b1;
      hresp             <= 1'b0;
      if (setup && !hwrite) hrdata <= rdata;
      sel_channel       <= cfg_ff.channel;
      sar_power_on      <= cfg_ff.channel != sadc_pkg::CH_OFF;
      sample_en         <= state_ff == sadc_pkg::ST_SAMPLE;
      analog_pin_enable <= analog_pin_enable_reg_ff;
      irq               <= (|(ist_ff & ien_ff)) | (done_ff & aien_ff);
    end
  end

  a_single_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_ff == sadc_pkg::ST_DONE && !cfg_ff.cont && !sc1_wr &&
     cfg_ff.channel != sadc_pkg::CH_OFF) |=> state_ff == sadc_pkg::ST_IDLE)
    else $error("single conversion did not return to idle");
  a_off_no_conv: assert property (@(posedge hclk) disable iff (!hresetn)
    (cfg_ff.channel == sadc_pkg::CH_OFF && !sc1_wr) |=> state_ff == sadc_pkg::ST_IDLE)
    else $error("conversion active while disabled");
  a_done_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    ((sc1_wr || low_rd) && !finish) |=> !done_ff)
    else $error("done flag not cleared");
  a_hw_start: assert property (@(posedge hclk) disable iff (!hresetn)
    (start && state_ff == sadc_pkg::ST_IDLE && !sc1_wr) |=> state_ff == sadc_pkg::ST_SAMPLE)
    else $error("hardware trigger did not start");
  a_cmp_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    (finish && cfg_ff.cmp_en && !cmp_true && !done_ff) |=> !done_ff)
    else $error("done set on false compare");
  a_res_fmt: assert property (@(posedge hclk) disable iff (!hresetn)
    (finish && !cfg_ff.mode10 && (!cfg_ff.cmp_en || cmp_true)) |=> res_ff[9:8] == 2'b00)
    else $error("8-bit result not right justified");
  a_irq_done: assert property (@(posedge hclk) disable iff (!hresetn)
    (done_ff && aien_ff) |=> irq)
    else $error("done interrupt missing");
  a_sc1_abort: assert property (@(posedge hclk) disable iff (!hresetn)
    (sc1_wr && hwdata[4:0] == sadc_pkg::CH_OFF) |=> state_ff == sadc_pkg::ST_IDLE)
    else $error("write did not abort");
  a_no_alt_clk: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_ff.clk_sel != sadc_pkg::CLK_ALT)
    else $error("alternate clock selected");
  a_cont_restart: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_ff == sadc_pkg::ST_DONE && cfg_ff.cont && !sc1_wr &&
     cfg_ff.channel != sadc_pkg::CH_OFF) |=> state_ff == sadc_pkg::ST_SAMPLE)
    else $error("continuous conversion did not restart");
  a_sw_start: assert property (@(posedge hclk) disable iff (!hresetn)
    (sc1_wr && hwdata[4:0] != sadc_pkg::CH_OFF && !cfg_ff.hw_trig) |=>
    state_ff == sadc_pkg::ST_SAMPLE)
    else $error("write did not start a conversion");
  a_done_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (finish && !cfg_ff.cmp_en) |=> done_ff)
    else $error("done flag not set on completion");
  a_irq_status: assert property (@(posedge hclk) disable iff (!hresetn)
    (|(ist_ff & ien_ff)) |=> irq)
    else $error("enabled status did not raise interrupt");
  a_trig_status: assert property (@(posedge hclk) disable iff (!hresetn)
    hw_conversion_trigger |=> ist_ff[sadc_pkg::IRQ_TRIG])
    else $error("trigger status not set");
  a_pwr_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (cfg_ff.channel == sadc_pkg::CH_OFF) |=> !sar_power_on)
    else $error("converter powered while disabled");
  a_sar_onehot: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_ff == sadc_pkg::ST_SAR) |-> ($onehot(bit_ff) && dac_code == sar_ff))
    else $error("trial bit or trial code broken");
  a_res_10bit: assert property (@(posedge hclk) disable iff (!hresetn)
    (finish && cfg_ff.mode10 && (!cfg_ff.cmp_en || cmp_true)) |=>
    res_ff == $past(final_code))
    else $error("10-bit result not stored");
  a_sample_len: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_ff == sadc_pkg::ST_SAMPLE && conv_tick && !sc1_wr &&
     cfg_ff.channel != sadc_pkg::CH_OFF && smp_ff == 3'(sadc_pkg::SAMPLE_CYC - 1)) |=>
    (state_ff == sadc_pkg::ST_SAR && bit_ff == 10'h200))
    else $error("approximation did not start at the top bit");
endmodule

// file: logic/sadc_pkg.sv
// Shared constants and carriers for the SAR converter sequencer.
// Assumes a single hclk domain and an AHB-Lite register slave.
package sadc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_SC1  = 8'h00;
  localparam logic [7:0] OFS_SC2  = 8'h04;
  localparam logic [7:0] OFS_RES  = 8'h08;
  localparam logic [7:0] OFS_CMP  = 8'h0C;
  localparam logic [7:0] OFS_CFG  = 8'h10;
  localparam logic [7:0] OFS_PIN  = 8'h14;
  localparam logic [7:0] OFS_WKP  = 8'h18;
  localparam logic [7:0] OFS_IST  = 8'h1C;
  localparam logic [7:0] OFS_IEN  = 8'h20;
  localparam logic [7:0] OFS_ICLR = 8'h24;
  // Control field positions
  localparam int SC1_AIEN = 6;
  localparam int SC1_CONT = 5;
  localparam int SC2_CMPGT = 4;
  localparam int SC2_CMPEN = 5;
  localparam int SC2_HWTRG = 6;
  localparam int SC2_ACTIVE = 7;
  localparam int CFG_MODE10 = 2;
  // Clock select codes
  localparam logic [1:0] CLK_BUS   = 2'h0;
  localparam logic [1:0] CLK_BUS2  = 2'h1;
  localparam logic [1:0] CLK_ALT   = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;
  // Reset values, widths and interrupt bit positions
  localparam logic [4:0] CH_OFF   = 5'h1F;
  localparam logic [3:0] WKP_RST  = 4'h0;
  localparam int RES_BITS = 10;
  localparam int IRQ_BITS = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TRIG = 1;
  // Local async clock divider and reference tick (nominal 32 kHz from 200 MHz)
  localparam int HCLK_MHZ   = 200;
  localparam int ASYNC_DIV  = 4;
  localparam int REF_KHZ    = 32;
  localparam int REF_CYC    = (HCLK_MHZ * 1000) / REF_KHZ;
  localparam int SAMPLE_CYC = 2;

  typedef struct packed {
    logic [1:0] clk_sel;
    logic       mode10;
    logic       cmp_en;
    logic       cmp_gt;
    logic       hw_trig;
    logic       cont;
    logic [4:0] channel;
  } sadc_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_SAR    = 2'b11,
    ST_DONE   = 2'b10
  } sadc_state_t;
endpackage

// file: logic/sadc_wakeup_ctr.sv
// Free-running periodic wake-up counter whose overflow is the hardware trigger.
// Assumes ext_ref_out comes from the clock module on another clock; it is synchronised here.
module sadc_wakeup_ctr #(
  parameter int REF_CYC = sadc_pkg::REF_CYC
) (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Configuration
  input  wire logic       use_ext_ref,
  input  wire logic [3:0] period_sel,
  input  wire logic       clock_module_ext_ref_out,
  // Trigger out
  output logic            overflow
);
  logic [2:0]  ref_sync_ff;
  logic [15:0] tick_ff;
  logic [15:0] cnt_ff;
  logic        ref_rise;
  logic        tick;

  // Three stages; a rising edge counts once stages two and three agree high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ref_sync_ff <= 3'h0;
    else          ref_sync_ff <= {ref_sync_ff[1:0], clock_module_ext_ref_out};
  end
  assign ref_rise = ref_sync_ff[1] & ref_sync_ff[2] & ~tick_ff[15];

  // Internal nominal 32 kHz tick; bit 15 remembers the last agreed ref level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tick_ff <= 16'h0000;
    else begin
      tick_ff[15] <= ref_sync_ff[1] & ref_sync_ff[2];
      if (tick_ff[14:0] >= 15'(REF_CYC - 1)) tick_ff[14:0] <= 15'h0000;
      else tick_ff[14:0] <= tick_ff[14:0] + 15'h0001;
    end
  end
  assign tick = use_ext_ref ? ref_rise : (tick_ff[14:0] == 15'h0000);

  // Counter runs freely in every power mode; overflow at 2^sel ticks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff   <= 16'h0000;
      overflow <= 1'b0;
    end else begin
      overflow <= 1'b0;
      if (tick) begin
        if (cnt_ff >= (16'h0001 << period_sel) - 16'h0001) begin
          cnt_ff   <= 16'h0000;
          overflow <= 1'b1;
        end else cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end
endmodule
